// ### hw/ecpp_map.svh
/*
  Constants of the parallel port engine: widths, depths, pin levels and timing.
  Assumes a single 40 ns clock and inclusion by bare name.
*/
`ifndef ECPP_MAP_SVH
`define ECPP_MAP_SVH

// One transfer unit is one byte
`define ECPP_BYTE_W 8
// FIFO entry: byte plus address/command tag above it
`define ECPP_ENTRY_W 9
`define ECPP_TAG_BIT 8
`define ECPP_FIFO_DEPTH 16
`define ECPP_FIFO_AW 4
// In a command byte this bit set means channel address, clear means run length
`define ECPP_ADDR_FLAG_BIT 7
`define ECPP_RUN_W 7

// Idle level of the active-low control pins
`define ECPP_PIN_IDLE 1'b1

// Compatibility strobe setup and width
`define ECPP_CLK_NS 40
`define ECPP_STROBE_NS 500
`define ECPP_STROBE_CYC ((`ECPP_STROBE_NS + `ECPP_CLK_NS - 1) / `ECPP_CLK_NS)
`define ECPP_CNT_W 4

`endif

// ### hw/ecpp_pkg.sv
/*
  Types of the parallel port engine: modes, engine states and state records.
  Assumes ecpp_map.svh on the include path.
*/
`include "ecpp_map.svh"

package ecpp_pkg;

  typedef enum logic [1:0] {
    ECPP_MODE_SPP = 2'b00,
    ECPP_MODE_COMPAT = 2'b01,
    ECPP_MODE_ECP = 2'b10,
    ECPP_MODE_RSVD = 2'b11
  } ecpp_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_F_SETUP = 4'b0001,
    ST_F_STB = 4'b0010,
    ST_F_WAIT = 4'b0011,
    ST_C_SET = 4'b0100,
    ST_C_STB = 4'b0101,
    ST_C_WAIT = 4'b0110,
    ST_T_REV = 4'b0111,
    ST_R_REQ = 4'b1000,
    ST_R_ACK = 4'b1001,
    ST_T_FWD = 4'b1010
  } ecpp_state_t;

  typedef struct packed {
    ecpp_state_t st;
    ecpp_mode_t mode;
    logic [`ECPP_CNT_W-1:0] cnt;
    logic [`ECPP_BYTE_W-1:0] pdata;
    logic oe;
    logic strobe_n;
    logic autofd_n;
    logic init_n;
    logic selin_n;
    logic tag;
    logic fault;
    logic online;
  } ecpp_main_t;

  typedef struct packed {
    logic [`ECPP_FIFO_AW:0] wp;
    logic [`ECPP_FIFO_AW:0] rp;
  } ecpp_fifo_t;

  typedef struct packed {
    logic [`ECPP_BYTE_W-1:0] byte_v;
    logic tag;
    logic valid;
    logic [`ECPP_RUN_W-1:0] cnt;
    logic [`ECPP_RUN_W-1:0] run;
    logic armed;
  } ecpp_rle_t;

endpackage

// ### hw/ecpp_fifo.sv
/*
  Shared byte FIFO with a tag bit per entry, valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`include "ecpp_map.svh"

module ecpp_fifo (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [`ECPP_ENTRY_W-1:0] wr_data,
  // Drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [`ECPP_ENTRY_W-1:0] rd_data,
  // Level
  output logic full,
  output logic empty
);

  ecpp_pkg::ecpp_fifo_t s_q;
  ecpp_pkg::ecpp_fifo_t s_d;
  logic [`ECPP_ENTRY_W-1:0] mem [`ECPP_FIFO_DEPTH];

  // Extra pointer bit tells full from empty when the low bits meet
  assign full = (s_q.wp[`ECPP_FIFO_AW] != s_q.rp[`ECPP_FIFO_AW]) &&
                (s_q.wp[`ECPP_FIFO_AW-1:0] == s_q.rp[`ECPP_FIFO_AW-1:0]);
  assign empty = (s_q.wp == s_q.rp);
  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data = mem[s_q.rp[`ECPP_FIFO_AW-1:0]];

  always_comb
  begin
    s_d = s_q;
    if (wr_valid && !full)
    begin
      s_d.wp = s_q.wp + 5'h01;
    end
    if (rd_ready && !empty)
    begin
      s_d.rp = s_q.rp + 5'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (wr_valid && !full)
    begin
      mem[s_q.wp[`ECPP_FIFO_AW-1:0]] <= wr_data;
    end
  end

endmodule

// ### hw/ecpp_rle.sv
/*
  Run-length expander for the reverse channel: swallows count bytes and
  repeats the next data byte. Assumes one clock, synchronous reset.
*/
`timescale 1ns/1ns
`include "ecpp_map.svh"

module ecpp_rle (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Bytes from the link
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [`ECPP_BYTE_W-1:0] in_data,
  input wire logic in_cmd,
  // Expanded bytes toward the FIFO
  output logic out_valid,
  input wire logic out_ready,
  output logic [`ECPP_ENTRY_W-1:0] out_data
);

  ecpp_pkg::ecpp_rle_t s_q;
  ecpp_pkg::ecpp_rle_t s_d;
  logic take;
  logic is_count;

  // Only one byte in hand; the link is held off while a run drains
  assign in_ready = !s_q.valid;
  assign out_valid = s_q.valid;
  assign out_data = {s_q.tag, s_q.byte_v};
  assign take = in_valid && in_ready;
  assign is_count = in_cmd && !in_data[`ECPP_ADDR_FLAG_BIT];

  always_comb
  begin
    s_d = s_q;
    if (s_q.valid && out_ready)
    begin
      if (s_q.cnt != '0)
      begin
        s_d.cnt = s_q.cnt - 7'h01;
      end
      else
      begin
        s_d.valid = 1'b0;
      end
    end
    if (take)
    begin
      if (is_count)
      begin
        s_d.run = in_data[`ECPP_RUN_W-1:0];
        s_d.armed = 1'b1;
      end
      else
      begin
        s_d.byte_v = in_data;
        s_d.tag = in_cmd;
        s_d.valid = 1'b1;
        // A count of N yields N+1 copies; channel addresses pass unexpanded
        s_d.cnt = (s_q.armed && !in_cmd) ? s_q.run : '0;
        s_d.armed = in_cmd ? s_q.armed : 1'b0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  chk_rle_swallow_count: assert property (@(posedge mclk) disable iff (reset)
    (take && is_count) |=> !out_valid)
    else $error("run-length byte was passed on");

  chk_rle_repeat_load: assert property (@(posedge mclk) disable iff (reset)
    (take && !in_cmd && s_q.armed) |=> (out_valid && s_q.cnt == $past(s_q.run)))
    else $error("repeat count not loaded");

endmodule

// ### hw/ecpp_port.sv
/*
  Parallel port transfer engine: conventional port, automatic compatibility
  handshake and the ECP forward/reverse channel with turnaround.
  Assumes pins sampled on mclk, mode and direction chosen by software.
*/
`timescale 1ns/1ns
`include "ecpp_map.svh"

module ecpp_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Mode and direction
  input ecpp_pkg::ecpp_mode_t mode,
  input wire logic dir_rev,
  // Conventional port levels
  input wire logic [`ECPP_BYTE_W-1:0] spp_data,
  input wire logic spp_strobe,
  input wire logic spp_autofd,
  input wire logic spp_init_n,
  input wire logic spp_selectin,
  input wire logic spp_dir,
  // Host write stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [`ECPP_BYTE_W-1:0] wr_data,
  input wire logic wr_addr,
  // Host read stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [`ECPP_BYTE_W-1:0] rd_data,
  output logic rd_cmd,
  // DMA and status
  output logic dma_req,
  output logic err_irq,
  output logic rev_active,
  output logic online,
  output logic fifo_full,
  output logic fifo_empty,
  // Port pins
  input wire logic [`ECPP_BYTE_W-1:0] pdata_in,
  output logic [`ECPP_BYTE_W-1:0] pdata_out,
  output logic pdata_oe,
  output logic strobe_n,
  output logic autofd_n,
  output logic init_n,
  output logic selectin_n,
  input wire logic busy,
  input wire logic ack_n,
  input wire logic perror,
  input wire logic fault_n,
  input wire logic select
);

  localparam int STB_W = `ECPP_STROBE_CYC;
  localparam logic [`ECPP_CNT_W-1:0] STB_LOAD = `ECPP_CNT_W'(STB_W - 1);
  // Strobe rises this many cycles after its second low cycle
  localparam int STB_TAIL = STB_W - 1;

  ecpp_pkg::ecpp_main_t s_q;
  ecpp_pkg::ecpp_main_t s_d;

  logic eng_pop;
  logic rle_in_valid;
  logic rle_in_ready;
  logic rle_out_valid;
  logic rle_out_ready;
  logic [`ECPP_ENTRY_W-1:0] rle_out_data;
  logic fifo_wr_valid;
  logic fifo_wr_ready;
  logic [`ECPP_ENTRY_W-1:0] fifo_wr_data;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [`ECPP_ENTRY_W-1:0] fifo_rd_data;
  logic rev;
  logic is_ecp;

  function automatic logic is_rev(input ecpp_pkg::ecpp_state_t st);
    is_rev = (st == ecpp_pkg::ST_T_REV) || (st == ecpp_pkg::ST_R_REQ) ||
             (st == ecpp_pkg::ST_R_ACK) || (st == ecpp_pkg::ST_T_FWD);
  endfunction

  assign rev = is_rev(s_q.st);
  assign is_ecp = (mode == ecpp_pkg::ECPP_MODE_ECP);

  // Shared FIFO: filled by the host forward, by the expander in reverse
  ecpp_fifo u_fifo (
    .mclk(mclk),
    .reset(reset),
    .wr_valid(fifo_wr_valid),
    .wr_ready(fifo_wr_ready),
    .wr_data(fifo_wr_data),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(fifo_rd_data),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  ecpp_rle u_rle (
    .mclk(mclk),
    .reset(reset),
    .in_valid(rle_in_valid),
    .in_ready(rle_in_ready),
    .in_data(pdata_in),
    .in_cmd(!busy),
    .out_valid(rle_out_valid),
    .out_ready(rle_out_ready),
    .out_data(rle_out_data)
  );

  assign fifo_wr_valid = rev ? rle_out_valid : (wr_valid && wr_ready);
  assign fifo_wr_data = rev ? rle_out_data : {wr_addr, wr_data};
  assign rle_out_ready = rev && fifo_wr_ready;
  assign wr_ready = !rev && (mode != ecpp_pkg::ECPP_MODE_SPP) && fifo_wr_ready;
  assign fifo_rd_ready = rev ? rd_ready : eng_pop;
  assign rd_valid = rev && fifo_rd_valid;
  assign rd_data = fifo_rd_data[`ECPP_BYTE_W-1:0];
  assign rd_cmd = fifo_rd_data[`ECPP_TAG_BIT];
  assign dma_req = rev ? !fifo_empty :
                   ((mode != ecpp_pkg::ECPP_MODE_SPP) && !fifo_full);

  assign pdata_out = s_q.pdata;
  assign pdata_oe = s_q.oe;
  assign strobe_n = s_q.strobe_n;
  assign autofd_n = s_q.autofd_n;
  assign init_n = s_q.init_n;
  assign selectin_n = s_q.selin_n;
  assign err_irq = s_q.fault;
  assign rev_active = rev;
  assign online = s_q.online;

  always_comb
  begin
    s_d = s_q;
    eng_pop = 1'b0;
    rle_in_valid = 1'b0;
    s_d.mode = mode;
    s_d.online = select;
    // Hint only: direction still follows dir_rev and the ECP mode alone
    s_d.fault = !fault_n && !rev;
    if (is_ecp)
    begin
      s_d.selin_n = `ECPP_PIN_IDLE;
    end
    else if (!rev)
    begin
      // Software levels wait until a reverse phase has been unwound
      s_d.selin_n = !spp_selectin;
      s_d.autofd_n = !spp_autofd;
      s_d.init_n = spp_init_n;
    end
    case (s_q.st)
      ecpp_pkg::ST_IDLE:
      begin
        s_d.strobe_n = `ECPP_PIN_IDLE;
        if (mode == ecpp_pkg::ECPP_MODE_SPP)
        begin
          s_d.pdata = spp_data;
          s_d.oe = !spp_dir;
          s_d.strobe_n = !spp_strobe;
        end
        else if (is_ecp && dir_rev)
        begin
          s_d.oe = 1'b0;
          s_d.autofd_n = 1'b0;
          s_d.init_n = 1'b0;
          s_d.st = ecpp_pkg::ST_T_REV;
        end
        else if (fifo_rd_valid && !busy)
        begin
          // Bytes go out as written, a run-length byte is software's job
          s_d.pdata = fifo_rd_data[`ECPP_BYTE_W-1:0];
          s_d.tag = fifo_rd_data[`ECPP_TAG_BIT];
          s_d.oe = 1'b1;
          s_d.cnt = STB_LOAD;
          if (is_ecp)
          begin
            s_d.autofd_n = !fifo_rd_data[`ECPP_TAG_BIT];
            s_d.init_n = `ECPP_PIN_IDLE;
            s_d.st = ecpp_pkg::ST_F_SETUP;
          end
          else
          begin
            s_d.st = ecpp_pkg::ST_C_SET;
          end
        end
        else if (is_ecp)
        begin
          s_d.oe = 1'b1;
          s_d.init_n = `ECPP_PIN_IDLE;
        end
        else
        begin
          s_d.oe = 1'b1;
        end
      end
      ecpp_pkg::ST_F_SETUP:
      begin
        if (!busy)
        begin
          s_d.strobe_n = 1'b0;
          s_d.st = ecpp_pkg::ST_F_STB;
        end
      end
      ecpp_pkg::ST_F_STB:
      begin
        if (busy)
        begin
          s_d.strobe_n = `ECPP_PIN_IDLE;
          eng_pop = 1'b1;
          s_d.st = ecpp_pkg::ST_F_WAIT;
        end
      end
      ecpp_pkg::ST_F_WAIT:
      begin
        if (!busy)
        begin
          s_d.st = ecpp_pkg::ST_IDLE;
        end
      end
      ecpp_pkg::ST_C_SET:
      begin
        if (s_q.cnt == '0)
        begin
          s_d.strobe_n = 1'b0;
          s_d.cnt = STB_LOAD;
          s_d.st = ecpp_pkg::ST_C_STB;
        end
        else
        begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      ecpp_pkg::ST_C_STB:
      begin
        if (s_q.cnt == '0)
        begin
          s_d.strobe_n = `ECPP_PIN_IDLE;
          eng_pop = 1'b1;
          s_d.st = ecpp_pkg::ST_C_WAIT;
        end
        else
        begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      ecpp_pkg::ST_C_WAIT:
      begin
        if (!busy)
        begin
          s_d.st = ecpp_pkg::ST_IDLE;
        end
      end
      ecpp_pkg::ST_T_REV:
      begin
        s_d.init_n = 1'b0;
        if (!perror)
        begin
          s_d.autofd_n = !rle_in_ready;
          s_d.st = ecpp_pkg::ST_R_REQ;
        end
      end
      ecpp_pkg::ST_R_REQ:
      begin
        // Peripheral may only drive while nAutoFd is low, so a byte is taken only then
        if (!s_q.autofd_n && !ack_n)
        begin
          rle_in_valid = 1'b1;
          s_d.autofd_n = `ECPP_PIN_IDLE;
          s_d.st = ecpp_pkg::ST_R_ACK;
        end
        else if (!dir_rev || !is_ecp)
        begin
          s_d.autofd_n = `ECPP_PIN_IDLE;
          if (s_q.autofd_n)
          begin
            s_d.init_n = `ECPP_PIN_IDLE;
            s_d.st = ecpp_pkg::ST_T_FWD;
          end
        end
        else
        begin
          s_d.autofd_n = !rle_in_ready;
        end
      end
      ecpp_pkg::ST_R_ACK:
      begin
        if (ack_n)
        begin
          s_d.st = ecpp_pkg::ST_R_REQ;
        end
      end
      ecpp_pkg::ST_T_FWD:
      begin
        s_d.init_n = `ECPP_PIN_IDLE;
        if (perror)
        begin
          s_d.oe = 1'b1;
          s_d.st = ecpp_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = ecpp_pkg::ST_IDLE;
      end
    endcase
    // A forward transfer cut by a mode change restarts from idle
    if ((mode != s_q.mode) && !rev)
    begin
      s_d.st = ecpp_pkg::ST_IDLE;
      s_d.strobe_n = `ECPP_PIN_IDLE;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_q <= '{st: ecpp_pkg::ST_IDLE, mode: ecpp_pkg::ECPP_MODE_SPP, cnt: '0,
               pdata: '0, oe: 1'b0, strobe_n: 1'b1, autofd_n: 1'b1,
               init_n: 1'b1, selin_n: 1'b1, tag: 1'b0, fault: 1'b0,
               online: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence fwd_latch_s;
    (s_q.st == ecpp_pkg::ST_F_STB) && busy;
  endsequence

  sequence compat_strobe_s;
    $fell(s_q.strobe_n) && (s_q.st == ecpp_pkg::ST_C_STB);
  endsequence

  chk_strobe_busy_low: assert property ($fell(s_q.strobe_n) &&
    (s_q.st == ecpp_pkg::ST_F_STB) |-> $past(!busy))
    else $error("forward strobe fell while busy high");

  chk_fwd_release: assert property (fwd_latch_s |=>
    (s_q.strobe_n && s_q.st == ecpp_pkg::ST_F_WAIT))
    else $error("strobe not released after busy rose");

  chk_compat_width: assert property (compat_strobe_s |->
    (!s_q.strobe_n)[*2] ##[STB_TAIL:STB_TAIL] s_q.strobe_n)
    else $error("compatibility strobe width wrong");

  chk_autofd_tag: assert property ($fell(s_q.strobe_n) &&
    (s_q.st == ecpp_pkg::ST_F_STB) |-> (s_q.autofd_n == !s_q.tag))
    else $error("nAutoFd does not match entry tag");

  chk_rev_no_drive: assert property ((s_q.st == ecpp_pkg::ST_R_REQ ||
    s_q.st == ecpp_pkg::ST_R_ACK || s_q.st == ecpp_pkg::ST_T_REV) |-> !s_q.oe)
    else $error("data bus driven during reverse");

  chk_fwd_after_ack: assert property ((s_q.st == ecpp_pkg::ST_T_FWD) &&
    !perror |=> !s_q.oe)
    else $error("bus driven before turnaround acknowledged");

  chk_init_rev: assert property ((s_q.st == ecpp_pkg::ST_R_REQ ||
    s_q.st == ecpp_pkg::ST_R_ACK) |-> !s_q.init_n)
    else $error("nInit high in reverse");

  chk_selin_ecp: assert property ((mode == ecpp_pkg::ECPP_MODE_ECP) |=>
    s_q.selin_n)
    else $error("nSelectIn asserted in ECP mode");

  chk_rev_stall: assert property ($fell(s_q.autofd_n) &&
    (s_q.st == ecpp_pkg::ST_R_REQ) |-> $past(rle_in_ready))
    else $error("reverse byte requested without room");

  chk_err_fwd_only: assert property ((s_q.st == ecpp_pkg::ST_R_REQ) ##1
    (s_q.st == ecpp_pkg::ST_R_REQ) |-> !err_irq)
    else $error("fault error raised in reverse");

endmodule

// ### testbench/ecpp_periph_model.sv
/*
  Behavioural peripheral on the far side of the parallel port pins.
  Assumes host pins are registered on mclk; changes its own pins just after an edge.
*/
`timescale 1ns/1ns

module ecpp_periph_model (
  // Clock
  input wire logic mclk,
  // Host pins
  input wire logic [7:0] pdata_out,
  input wire logic strobe_n,
  input wire logic autofd_n,
  input wire logic init_n,
  input wire logic selectin_n,
  // Peripheral pins
  output logic [7:0] pd,
  output logic busy,
  output logic ack_n,
  output logic perror,
  // Behaviour control
  input wire logic stall,
  input wire logic [31:0] lag
);
  // Entries are {address or command flag, byte}
  logic [8:0] fwd_q[$];
  logic [8:0] rev_q[$];
  logic [8:0] e;

  task automatic tick(input int n);
    repeat (n + 1) @(posedge mclk);
    #2;
  endtask

  initial
  begin
    pd = 8'h00;
    busy = 1'b0;
    ack_n = 1'b1;
    perror = 1'b1;
    forever
    begin
      tick(0);
      if (perror && strobe_n === 1'b0 && !busy && !stall)
      begin
        fwd_q.push_back({!autofd_n, pdata_out});
        tick(lag);
        busy = 1'b1;
        while (!strobe_n)
          tick(0);
        tick(lag);
        busy = 1'b0;
      end
      else if (perror && init_n === 1'b0)
      begin
        tick(lag);
        perror = 1'b0;
      end
      else if (!perror && init_n === 1'b1)
      begin
        tick(lag);
        busy = 1'b0;
        perror = 1'b1;
      end
      else if (!perror && autofd_n === 1'b0 && selectin_n && rev_q.size() > 0)
      begin
        e = rev_q.pop_front();
        pd = e[7:0];
        busy = !e[8];
        tick(lag);
        ack_n = 1'b0;
        while (!autofd_n)
          tick(0);
        ack_n = 1'b1;
        // Released bus shows a changed value so a stale sample is caught
        pd = ~pd;
      end
    end
  end
endmodule

// ### testbench/tb.sv
/*
  Self-checking bench for the parallel port engine.
  Assumes the design package and map header are compiled first.
*/
`timescale 1ns/1ns
`include "ecpp_map.svh"

`define CHK(got, exp, msg) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("[FAIL] %0t %s", $time, msg); \
    end \
  end

module tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  ecpp_pkg::ecpp_mode_t mode = ecpp_pkg::ECPP_MODE_ECP;
  logic dir_rev = 1'b0;
  logic [`ECPP_BYTE_W-1:0] spp_data = 8'h00;
  logic spp_strobe = 1'b0;
  logic spp_autofd = 1'b0;
  logic spp_dir = 1'b0;
  logic spp_selectin = 1'b1;
  logic wr_valid = 1'b0;
  logic [`ECPP_BYTE_W-1:0] wr_data = 8'h00;
  logic wr_addr = 1'b0;
  logic rd_ready = 1'b0;
  logic fault_n = 1'b1;
  logic stall = 1'b0;
  int lag = 0;
  int failures = 0;
  int total_checks = 0;
  logic wr_ready, rd_valid, rd_cmd, dma_req, err_irq, rev_active, online;
  logic fifo_full, fifo_empty, pdata_oe, strobe_n, autofd_n, init_n, selectin_n;
  logic busy, ack_n, perror;
  logic [`ECPP_BYTE_W-1:0] rd_data, pdata_out, pdata_in, pd;

  // Host drives the bus while enabled, otherwise the peripheral's lines show
  assign pdata_in = pdata_oe ? pdata_out : pd;

  ecpp_port uut (
    .mclk(mclk), .reset(reset), .mode(mode), .dir_rev(dir_rev),
    .spp_data(spp_data), .spp_strobe(spp_strobe), .spp_autofd(spp_autofd),
    .spp_init_n(1'b1), .spp_selectin(spp_selectin), .spp_dir(spp_dir),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_addr(wr_addr),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .rd_cmd(rd_cmd),
    .dma_req(dma_req), .err_irq(err_irq), .rev_active(rev_active), .online(online),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty), .pdata_in(pdata_in),
    .pdata_out(pdata_out), .pdata_oe(pdata_oe), .strobe_n(strobe_n),
    .autofd_n(autofd_n), .init_n(init_n), .selectin_n(selectin_n), .busy(busy),
    .ack_n(ack_n), .perror(perror), .fault_n(fault_n), .select(1'b1)
  );

  ecpp_periph_model per (
    .mclk(mclk), .pdata_out(pdata_out), .strobe_n(strobe_n), .autofd_n(autofd_n),
    .init_n(init_n), .selectin_n(selectin_n), .pd(pd), .busy(busy), .ack_n(ack_n),
    .perror(perror), .stall(stall), .lag(lag)
  );

  always #20 mclk = ~mclk;

  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tmo(input string what);
    failures++;
    $display("[FAIL] %0t timeout %s", $time, what);
    report_and_stop();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  // Leaves wr_valid high so back-to-back writes never assign it twice in a step
  task automatic wr(input logic [7:0] d, input logic a);
    int i;
    wr_valid = 1'b1;
    wr_data = d;
    wr_addr = a;
    for (i = 0; i < 300; i++)
    begin
      @(negedge mclk);
      if (wr_ready === 1'b1)
        break;
    end
    if (i == 300)
      tmo("write");
    cyc(1);
  endtask

  // Also waits for the engine to finish, so a later mode change cuts no transfer
  task automatic fwd_wait(input int n);
    int i;
    for (i = 0; i < 2000 && (per.fwd_q.size() < n || fifo_empty !== 1'b1 ||
         strobe_n !== 1'b1 || busy !== 1'b0); i++)
      cyc(1);
    if (i == 2000)
      tmo("forward bytes");
  endtask

  task automatic t_reset();
    `CHK(strobe_n & autofd_n & init_n & selectin_n, 1'b1, "pins idle")
    `CHK(pdata_oe, 1'b0, "bus driven at reset")
    `CHK(fifo_empty, 1'b1, "fifo not empty")
    `CHK(err_irq, 1'b0, "error at reset")
    reset = 1'b0;
    cyc(1);
    `CHK(online, 1'b1, "online copy")
    `CHK(pdata_oe, perror, "forward bus after release")
  endtask

  task automatic t_fwd();
    per.fwd_q.delete();
    lag = 2;
    wr(8'h3C, 1'b0);
    wr(8'h81, 1'b1);
    wr(8'h00, 1'b0);
    wr_valid = 1'b0;
    fwd_wait(3);
    `CHK(per.fwd_q[0], 9'h03C, "first byte")
    `CHK(per.fwd_q[1], 9'h181, "address byte tag")
    `CHK(per.fwd_q[2], 9'h000, "third byte")
    `CHK(selectin_n, 1'b1, "select in during ecp")
    `CHK(dma_req, 1'b1, "no dma request with room")
  endtask

  task automatic t_full();
    int i;
    per.fwd_q.delete();
    lag = 0;
    stall = 1'b1;
    for (i = 0; i < `ECPP_FIFO_DEPTH; i++)
      wr(8'(i * 17), i[0]);
    @(negedge mclk);
    `CHK(wr_ready, 1'b0, "write taken when full")
    `CHK(fifo_full, 1'b1, "full flag")
    `CHK(dma_req, 1'b0, "dma request when full")
    cyc(1);
    wr_valid = 1'b0;
    stall = 1'b0;
    fwd_wait(`ECPP_FIFO_DEPTH);
    for (i = 0; i < `ECPP_FIFO_DEPTH; i++)
      `CHK(per.fwd_q[i], {i[0], 8'(i * 17)}, "drained byte")
    `CHK(per.fwd_q.size(), `ECPP_FIFO_DEPTH, "duplicated byte")
  endtask

  task automatic t_compat();
    int i;
    int w;
    per.fwd_q.delete();
    mode = ecpp_pkg::ECPP_MODE_COMPAT;
    spp_autofd = 1'b1;
    wr(8'hA7, 1'b0);
    wr_valid = 1'b0;
    for (i = 0; i < 300 && strobe_n !== 1'b0; i++)
      cyc(1);
    if (i == 300)
      tmo("compat strobe start");
    for (w = 0; w < 300 && strobe_n === 1'b0; w++)
      cyc(1);
    if (w == 300)
      tmo("compat strobe end");
    `CHK(w, `ECPP_STROBE_CYC, "strobe width")
    fwd_wait(1);
    `CHK(per.fwd_q[0], 9'h1A7, "compat byte with autofeed level")
    spp_autofd = 1'b0;
  endtask

  task automatic t_spp();
    mode = ecpp_pkg::ECPP_MODE_SPP;
    spp_data = 8'h5A;
    spp_strobe = 1'b1;
    cyc(2);
    `CHK({pdata_oe, pdata_out, strobe_n}, 10'h2B4, "direct pins")
    `CHK(wr_ready, 1'b0, "fifo open in direct mode")
    `CHK(selectin_n, 1'b0, "select in follows software")
    spp_dir = 1'b1;
    spp_strobe = 1'b0;
    cyc(2);
    `CHK({pdata_oe, strobe_n}, 2'b01, "bus released for input")
    spp_dir = 1'b0;
    mode = ecpp_pkg::ECPP_MODE_ECP;
    cyc(2);
  endtask

  task automatic t_rev();
    int i;
    logic [8:0] got[$];
    logic [8:0] exp[$];
    exp = '{9'h05A, 9'h05A, 9'h05A, 9'h05A, 9'h185, 9'h011};
    lag = 1;
    per.rev_q = '{9'h103, 9'h05A, 9'h185, 9'h011};
    dir_rev = 1'b1;
    rd_ready = 1'b1;
    for (i = 0; i < 200 && perror !== 1'b0; i++)
      cyc(1);
    if (i == 200)
      tmo("reverse turnaround");
    `CHK({init_n, rev_active}, 2'b01, "reverse request")
    fault_n = 1'b0;
    for (i = 0; i < 600 && got.size() < 6; i++)
    begin
      @(negedge mclk);
      `CHK(pdata_oe | err_irq, 1'b0, "bus or error in reverse")
      if (rd_valid === 1'b1)
      begin
        `CHK(dma_req, 1'b1, "no dma request with reverse data")
        got.push_back({rd_cmd, rd_data});
      end
    end
    if (i == 600)
      tmo("reverse bytes");
    `CHK(got.size(), 6, "reverse count")
    for (i = 0; i < 6 && i < got.size(); i++)
      `CHK(got[i], exp[i], "reverse byte")
    cyc(1);
    rd_ready = 1'b0;
    dir_rev = 1'b0;
    for (i = 0; i < 300 && pdata_oe !== 1'b1; i++)
    begin
      @(negedge mclk);
      `CHK(pdata_oe & !perror, 1'b0, "bus driven before turnaround")
    end
    if (i == 300)
      tmo("forward turnaround");
    `CHK({init_n, perror}, 2'b11, "forward restored")
    cyc(2);
    `CHK(err_irq, 1'b1, "error in forward")
    fault_n = 1'b1;
    cyc(2);
  endtask

  initial
  begin
    repeat (8) @(posedge mclk);
    #2;
    t_reset();
    t_fwd();
    t_full();
    t_compat();
    t_spp();
    t_rev();
    report_and_stop();
  end
endmodule
